/* File: design/sfc_area_map.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sfc_regs.svh"
// Boot start address and halting-area decode
module sfc_area_map
   import sfc_pkg::*;
(
   // Fuse and page
   input wire logic [1:0] boot_sel,
   input wire sfc_page_t page,
   // Decode results
   output logic [12:0] boot_start,
   output logic in_halting
);
   // Larger boot areas start lower
   always_comb begin
      unique case (boot_sel)
         2'h3: boot_start = `SFC_BOOT_128;
         2'h2: boot_start = `SFC_BOOT_256;
         2'h1: boot_start = `SFC_BOOT_512;
         2'h0: boot_start = `SFC_BOOT_1024;
      endcase
   end

   assign in_halting = page >= `SFC_FIRST_HALT_PAGE;
endmodule
`default_nettype wire

/* File: design/sfc_ctrl.sv */
// Local design decision: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "sfc_regs.svh"
module sfc_ctrl
   import sfc_pkg::*;
#(
   parameter int PROG_CYCLES = `SFC_PROG_TIME_US * 1000 / `SFC_CLK_PERIOD_NS
)(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Processor core
   input wire logic store_req,
   input wire logic load_req,
   input wire logic [15:0] flash_addr_pointer,
   input wire logic [7:0] data_low_reg,
   input wire logic [7:0] data_high_reg,
   input wire logic global_irq_en,
   output logic [7:0] load_data,
   output logic load_valid,
   output logic stall_core,
   output logic irq_req,
   // Fuses
   input wire logic [1:0] boot_area_size_sel,
   input wire logic [7:0] fuse_bits,
   // Flash array side
   input wire sfc_word_t pb_rd_idx,
   output logic [15:0] pb_rd_data,
   output logic flash_erase,
   output logic flash_write,
   output sfc_page_t flash_page,
   output logic [7:0] lock_bits,
   output logic rww_block,
   output logic [12:0] boot_start
);
   sfc_state_e state_q;
   logic [4:0] cmd_q;
   logic irq_en_q, rww_busy_q, ready_q, err_q, stall_q, ld_valid_q;
   logic erase_q, write_q;
   logic [2:0] win_q;
   logic [31:0] op_cnt_q;
   logic [31:0] rdata_q;
   logic [7:0] lock_q, ld_data_q, fuse_q;
   logic [1:0] boot_meta_q, boot_sel_q;
   logic [7:0] fuse_meta_q;
   logic [12:0] boot_start_q;
   sfc_page_t page_q;
   logic [12:0] boot_start_c;
   logic in_halt_c, pb_loaded;
   logic [7:0] csr_rd;
   logic hit, wr_csr, legal, op_run, store_go, load_go, fill_go, discard;
   sfc_page_t ptr_page;
   sfc_word_t ptr_word;

   // ---------------------------------------------------------
   // Pointer split and bus decode
   // ---------------------------------------------------------
   assign ptr_page = flash_addr_pointer[13:7];
   assign ptr_word = flash_addr_pointer[6:1];
   assign hit = paddr == `SFC_CSR_ADDR;
   assign wr_csr = psel && penable && ready_q && pwrite && hit;
   assign legal = pwdata[4:0] == `SFC_CMD_REENABLE || pwdata[4:0] == `SFC_CMD_LOCK_WR
      || pwdata[4:0] == `SFC_CMD_PG_PROG || pwdata[4:0] == `SFC_CMD_PG_CLEAR
      || pwdata[4:0] == `SFC_CMD_FILL;
   assign op_run = state_q == ST_ERASE || state_q == ST_WRITE;
   // Stores only count while the window is open
   // A legal register write in the same cycle wins and drops the store
   assign store_go = store_req && state_q == ST_ARMED && win_q != 3'h0
      && !(wr_csr && legal);
   assign load_go = load_req && state_q == ST_ARMED && cmd_q == `SFC_CMD_LOCK_WR
      && win_q > (`SFC_STORE_WIN - `SFC_LOAD_WIN);
   assign fill_go = store_go && cmd_q == `SFC_CMD_FILL;
   // A re-enable during loading throws the buffer away
   assign discard = wr_csr && legal && !op_run && pwdata[4:0] == `SFC_CMD_REENABLE
      && pb_loaded;
   // Bit 5 reserved zero, bit 6 from hardware
   assign csr_rd = {irq_en_q, rww_busy_q, 1'b0, cmd_q};

   // ---------------------------------------------------------
   // APB slave, one wait-free access phase
   // ---------------------------------------------------------
   // Ready is raised by the setup cycle so every access ends at the first access edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ready_q <= psel && !penable;
         err_q <= psel && !penable && !hit;
         if (psel && !penable) begin
            rdata_q <= hit ? {24'h0, csr_rd} : 32'h0;
         end
      end
   end

   // ---------------------------------------------------------
   // Fuse capture, two flops deep because the straps come from outside
   // ---------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_meta_q <= 2'h0;
         boot_sel_q <= 2'h0;
         fuse_meta_q <= 8'h0;
         fuse_q <= 8'h0;
         boot_start_q <= 13'h0;
      end else begin
         boot_meta_q <= boot_area_size_sel;
         boot_sel_q <= boot_meta_q;
         fuse_meta_q <= fuse_bits;
         fuse_q <= fuse_meta_q;
         boot_start_q <= boot_start_c;
      end
   end

   // ---------------------------------------------------------
   // Sequencer: arming window, commands, erase/write timing
   // ---------------------------------------------------------
   // A write during erase/write must not touch the command bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         cmd_q <= 5'h0;
         irq_en_q <= 1'b0;
         win_q <= 3'h0;
         op_cnt_q <= 32'h0;
         page_q <= '0;
      end else begin
         if (wr_csr) begin
            irq_en_q <= pwdata[`SFC_BIT_IRQ_EN];
         end
         unique case (state_q)
            ST_IDLE, ST_ARMED: begin
               if (wr_csr && legal) begin
                  state_q <= ST_ARMED;
                  cmd_q <= pwdata[4:0];
                  win_q <= `SFC_STORE_WIN;
               end else if (store_go && cmd_q == `SFC_CMD_PG_CLEAR) begin
                  state_q <= ST_ERASE;
                  page_q <= ptr_page;
                  op_cnt_q <= 32'(PROG_CYCLES);
               end else if (store_go && cmd_q == `SFC_CMD_PG_PROG) begin
                  state_q <= ST_WRITE;
                  page_q <= ptr_page;
                  op_cnt_q <= 32'(PROG_CYCLES);
               end else if (store_go || (state_q == ST_ARMED && win_q == 3'h1)) begin
                  state_q <= ST_IDLE;
                  cmd_q <= 5'h0;
                  win_q <= 3'h0;
               end else if (win_q != 3'h0) begin
                  win_q <= win_q - 3'h1;
               end
            end
            ST_ERASE, ST_WRITE: begin
               // Arm bit stays set until the flash finishes
               if (op_cnt_q <= 32'h1) begin
                  state_q <= ST_IDLE;
                  cmd_q <= 5'h0;
                  win_q <= 3'h0;
               end else begin
                  op_cnt_q <= op_cnt_q - 32'h1;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------
   // Flash strobes, stall and concurrent-read busy
   // ---------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erase_q <= 1'b0;
         write_q <= 1'b0;
         stall_q <= 1'b0;
      end else begin
         erase_q <= store_go && cmd_q == `SFC_CMD_PG_CLEAR && !(wr_csr && legal);
         write_q <= store_go && cmd_q == `SFC_CMD_PG_PROG && !(wr_csr && legal);
         if ((erase_q || write_q) && in_halt_c) begin
            stall_q <= 1'b1;
         end else if (!op_run) begin
            stall_q <= 1'b0;
         end
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rww_busy_q <= 1'b0;
      end else if ((erase_q || write_q) && !in_halt_c) begin
         rww_busy_q <= 1'b1;
      end else if (fill_go || (store_go && cmd_q == `SFC_CMD_REENABLE)) begin
         rww_busy_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------
   // Lock bits and load return
   // ---------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_q <= `SFC_LOCK_RESET;
         ld_data_q <= 8'h0;
         ld_valid_q <= 1'b0;
      end else begin
         if (store_go && cmd_q == `SFC_CMD_LOCK_WR) begin
            lock_q <= data_low_reg;
         end
         ld_valid_q <= load_go;
         if (load_go) begin
            ld_data_q <= flash_addr_pointer[0] ? fuse_q : lock_q;
         end
      end
   end

   // ---------------------------------------------------------
   // Submodules
   // ---------------------------------------------------------
   sfc_page_buf u_buf (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(fill_go),
      .wr_idx(ptr_word),
      .wr_data({data_high_reg, data_low_reg}),
      .discard(discard),
      .rd_idx(pb_rd_idx),
      .rd_data_q(pb_rd_data),
      .any_loaded(pb_loaded)
   );

   sfc_area_map u_map (
      .boot_sel(boot_sel_q),
      .page(page_q),
      .boot_start(boot_start_c),
      .in_halting(in_halt_c)
   );

   // ---------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------
   // Interrupt level registered; one cycle behind the arm bit
   logic irq_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_en_q && global_irq_en && !cmd_q[`SFC_BIT_ARM];
      end
   end

   assign prdata = rdata_q;
   assign pready = ready_q;
   assign pslverr = err_q;
   assign load_data = ld_data_q;
   assign load_valid = ld_valid_q;
   assign stall_core = stall_q;
   assign irq_req = irq_q;
   assign flash_erase = erase_q;
   assign flash_write = write_q;
   assign flash_page = page_q;
   assign lock_bits = lock_q;
   assign rww_block = rww_busy_q;
   assign boot_start = boot_start_q;

   // ---------------------------------------------------------
   // Checks
   // ---------------------------------------------------------
   chk_late_store: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_ARMED && win_q == 3'h1 && !store_go && !(wr_csr && legal))
      |=> ##1 !flash_erase && !flash_write)
      else $error("store after window acted");
   chk_illegal_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_csr && !legal && state_q == ST_IDLE) |=> cmd_q == $past(cmd_q))
      else $error("illegal pattern changed command bits");
   chk_rww_set: assert property (@(posedge pclk) disable iff (!presetn)
      (store_go && cmd_q == `SFC_CMD_PG_CLEAR && ptr_page < `SFC_FIRST_HALT_PAGE
      && !(wr_csr && legal)) |=> ##1 rww_block)
      else $error("busy not set for concurrent-area erase");
   chk_fill_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (fill_go && !erase_q && !write_q) |=> !rww_block)
      else $error("fill did not clear busy");
   chk_halt_stall: assert property (@(posedge pclk) disable iff (!presetn)
      (write_q && in_halt_c) |=> stall_core throughout (op_run [*2]))
      else $error("core not stalled during halting write");
   chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      (irq_en_q && global_irq_en && !cmd_q[0]) |=> irq_req)
      else $error("ready interrupt missing");
   chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && hit) |=> prdata[5] == 1'b0 && prdata[31:8] == 24'h0)
      else $error("reserved bits not zero");
   chk_arm_expire: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_csr && legal && state_q != ST_ERASE && state_q != ST_WRITE && !store_req)
      ##1 !store_req [*4] |=> cmd_q == 5'h0 || $past(wr_csr) || $past(wr_csr, 2)
      || $past(wr_csr, 3))
      else $error("arming did not expire");
   chk_lock_write: assert property (@(posedge pclk) disable iff (!presetn)
      (store_go && cmd_q == `SFC_CMD_LOCK_WR && !(wr_csr && legal))
      |=> lock_bits == $past(data_low_reg))
      else $error("lock bits not taken from low data");
   chk_arm_held: assert property (@(posedge pclk) disable iff (!presetn)
      op_run |-> cmd_q[`SFC_BIT_ARM])
      else $error("arm bit dropped during erase or write");
   chk_busy_refuse: assert property (@(posedge pclk) disable iff (!presetn)
      (op_run && op_cnt_q > 32'h1 && wr_csr) |=> cmd_q == $past(cmd_q) && op_run)
      else $error("command accepted during erase or write");
   chk_discard_buf: assert property (@(posedge pclk) disable iff (!presetn)
      discard |=> !pb_loaded)
      else $error("buffer kept after re-enable");
   chk_load_return: assert property (@(posedge pclk) disable iff (!presetn)
      load_go |=> load_valid && load_data == ($past(flash_addr_pointer[0]) ? $past(fuse_q) : $past(lock_q)))
      else $error("load did not return lock or fuse bits");
endmodule
`default_nettype wire

/* File: design/sfc_page_buf.sv */
`timescale 1ns/1ns
`default_nettype none
// Temporary page buffer, 64 words of 16 bits, registered read port
module sfc_page_buf
   import sfc_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Fill port
   input wire logic wr_en,
   input wire sfc_word_t wr_idx,
   input wire logic [15:0] wr_data,
   input wire logic discard,
   // Read port and fill state
   input wire sfc_word_t rd_idx,
   output logic [15:0] rd_data_q,
   output logic any_loaded
);
   logic [15:0] mem [64];
   logic [63:0] valid_q;

   // ---------------------------------------------------------
   // Storage and per-entry valid flags
   // ---------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 64; gi++) begin : g_ent
         // Discard drops only the flag, data need no reset
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               valid_q[gi] <= 1'b0;
            end else if (discard) begin
               valid_q[gi] <= 1'b0;
            end else if (wr_en && wr_idx == sfc_word_t'(gi)) begin
               valid_q[gi] <= 1'b1;
            end
         end
         always_ff @(posedge pclk) begin
            if (wr_en && !discard && wr_idx == sfc_word_t'(gi)) begin
               mem[gi] <= wr_data;
            end
         end
      end
   endgenerate

   assign any_loaded = |valid_q;

   // Unloaded words read as erased flash
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data_q <= 16'hffff;
      end else begin
         rd_data_q <= valid_q[rd_idx] ? mem[rd_idx] : 16'hffff;
      end
   end
endmodule
`default_nettype wire

/* File: design/sfc_pkg.sv */
package sfc_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_ERASE,
      ST_WRITE
   } sfc_state_e;
   typedef logic [5:0] sfc_word_t;
   typedef logic [6:0] sfc_page_t;
endpackage

/* File: design/sfc_regs.svh */
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH
// Register index and byte address of the control/status register
`define SFC_CSR_INDEX 8'h37
`define SFC_CSR_ADDR 8'hdc
`define SFC_CSR_RESET 8'h00
// Field positions in the control/status register
`define SFC_BIT_IRQ_EN 7
`define SFC_BIT_RWW_BUSY 6
`define SFC_BIT_RSVD 5
`define SFC_BIT_REENABLE 4
`define SFC_BIT_LOCK_WR 3
`define SFC_BIT_PG_PROG 2
`define SFC_BIT_PG_CLEAR 1
`define SFC_BIT_ARM 0
// Accepted low five bit patterns
`define SFC_CMD_REENABLE 5'h11
`define SFC_CMD_LOCK_WR 5'h09
`define SFC_CMD_PG_PROG 5'h05
`define SFC_CMD_PG_CLEAR 5'h03
`define SFC_CMD_FILL 5'h01
// Arming windows in cycles
`define SFC_STORE_WIN 3'h4
`define SFC_LOAD_WIN 3'h3
// Flash geometry
`define SFC_FIRST_HALT_PAGE 7'h70
`define SFC_BOOT_128 13'h1f80
`define SFC_BOOT_256 13'h1f00
`define SFC_BOOT_512 13'h1e00
`define SFC_BOOT_1024 13'h1c00
// Erase/write time
`define SFC_PROG_TIME_US 4000
`define SFC_CLK_PERIOD_NS 10
`define SFC_LOCK_RESET 8'hff
`endif

/* File: dv/self_program_flash_control_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sfc_regs.svh"
module self_program_flash_control_tb
   import sfc_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, global_irq_en, err;
   logic pready, pslverr, store_req, load_req, load_valid, stall_core, irq_req;
   logic flash_erase, flash_write, rww_block;
   logic [7:0] paddr, fuse_bits, load_data, lock_bits, data_low_reg, data_high_reg;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] flash_addr_pointer, pb_rd_data;
   logic [1:0] boot_area_size_sel;
   logic [12:0] boot_start;
   logic [12:0] bstart [4] = '{13'h1f80, 13'h1f00, 13'h1e00, 13'h1c00};
   logic [7:0] bad_pat [4] = '{8'h07, 8'h13, 8'h1f, 8'h02};
   sfc_word_t pb_rd_idx;
   sfc_page_t flash_page;
   int bad_count, check_count;

   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   sfc_ctrl #(.PROG_CYCLES(20)) sfc_ctrl_inst (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .store_req(store_req),
      .load_req(load_req), .flash_addr_pointer(flash_addr_pointer), .data_low_reg(data_low_reg),
      .data_high_reg(data_high_reg), .global_irq_en(global_irq_en), .load_data(load_data),
      .load_valid(load_valid), .stall_core(stall_core), .irq_req(irq_req),
      .boot_area_size_sel(boot_area_size_sel), .fuse_bits(fuse_bits), .pb_rd_idx(pb_rd_idx),
      .pb_rd_data(pb_rd_data), .flash_erase(flash_erase), .flash_write(flash_write),
      .flash_page(flash_page), .lock_bits(lock_bits), .rww_block(rww_block), .boot_start(boot_start));

   sfc_core_model sfc_core_model_inst (
      .pclk(pclk), .store_req(store_req), .load_req(load_req), .flash_addr_pointer(flash_addr_pointer),
      .data_low_reg(data_low_reg), .data_high_reg(data_high_reg));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
         bad_count++;
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic give_up(input string what);
      $display("[FAIL] %0t timeout %s", $time, what);
      bad_count++;
      stop_test();
   endtask
   // One APB transfer; request held until pready is seen at a rising edge
   // Starts on the next edge so back-to-back calls never drive psel twice in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) give_up("pready");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] d);
      apb(1'b1, `SFC_CSR_ADDR, {24'h0, d});
   endtask
   task automatic rdc(input logic [7:0] exp, input string what);
      apb(1'b0, `SFC_CSR_ADDR, 32'h0);
      chk(rd, {24'h0, exp}, what);
   endtask
   task automatic wait_hi(ref logic s, input string what);
      int n;
      n = 0;
      // Let the launching edge settle so a one-cycle pulse is not missed
      #1;
      while (s !== 1'b1 && n < 50) begin
         @(posedge pclk);
         #1;
         n++;
      end
      if (s !== 1'b1) give_up(what);
   endtask
   // Polls until the arm bit drops; a long operation keeps it set
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, `SFC_CSR_ADDR, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 40);
      if (rd[0] !== 1'b0) give_up("op");
   endtask
   task automatic peek(input sfc_word_t idx, input logic [15:0] exp, input string what);
      pb_rd_idx <= idx;
      repeat (2) @(posedge pclk);
      #1;
      chk(pb_rd_data, exp, what);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      #400000;
      give_up("run");
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, global_irq_en} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fuse_bits = 8'h3c;
      boot_area_size_sel = 2'b11;
      pb_rd_idx = '0;
      bad_count = 0;
      check_count = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      cyc(1);
      chk(lock_bits, 8'hff, "lock reset");
      rdc(8'h00, "csr reset");
      apb(1'b0, 8'h10, 32'h0);
      chk(err, 1'b1, "unmapped err");
      for (int i = 0; i < 4; i++) begin
         boot_area_size_sel <= 2'(3 - i);
         cyc(3);
         chk(boot_start, bstart[i], "boot start");
      end
      wr(8'h60);
      rdc(8'h00, "ro bits");
      foreach (bad_pat[i]) begin
         wr(bad_pat[i]);
         rdc(8'h00, "bad pattern");
      end
      // Ready interrupt follows enable, global enable and a clear arm bit
      global_irq_en <= 1'b1;
      wr(8'h80);
      cyc(2);
      chk(irq_req, 1'b1, "irq on");
      wr(8'h81);
      cyc(1);
      chk(irq_req, 1'b0, "irq armed");
      cyc(6);
      chk(irq_req, 1'b1, "irq expired");
      global_irq_en <= 1'b0;
      cyc(2);
      chk(irq_req, 1'b0, "irq gated");
      // Buffer fill with stray pointer bits set
      wr(8'h01);
      sfc_core_model_inst.issue(1'b0, 16'hc00b, 8'h34, 8'h12);
      rdc(8'h00, "arm clears");
      peek(6'd5, 16'h1234, "fill");
      wr(8'h01);
      cyc(5);
      sfc_core_model_inst.issue(1'b0, 16'h000c, 8'h78, 8'h56);
      peek(6'd6, 16'hffff, "late store");
      rdc(8'h00, "window expired");
      // Erase in the concurrent-read area
      wr(8'h03);
      sfc_core_model_inst.issue(1'b0, 16'h0180, 8'h00, 8'h00);
      wait_hi(flash_erase, "erase");
      chk(flash_page, 7'h03, "erase page");
      cyc(1);
      chk(rww_block, 1'b1, "busy erase");
      chk(stall_core, 1'b0, "no stall");
      rdc(8'h43, "busy held");
      wait_idle();
      rdc(8'h40, "erase done");
      wr(8'h01);
      sfc_core_model_inst.issue(1'b0, 16'h0000, 8'hcd, 8'hab);
      cyc(2);
      chk(rww_block, 1'b0, "fill frees");
      wr(8'h11);
      peek(6'd0, 16'hffff, "discard");
      // Page write in the halting area stalls the core
      wr(8'h05);
      sfc_core_model_inst.issue(1'b0, 16'h3880, 8'h00, 8'h00);
      wait_hi(flash_write, "write");
      chk(flash_page, 7'h71, "write page");
      cyc(1);
      chk(stall_core, 1'b1, "stall");
      chk(rww_block, 1'b0, "halting no busy");
      wait_idle();
      cyc(2);
      chk(stall_core, 1'b0, "stall end");
      // Re-enable refused mid-operation, accepted afterwards
      wr(8'h05);
      sfc_core_model_inst.issue(1'b0, 16'h0100, 8'h00, 8'h00);
      wait_hi(rww_block, "busy");
      wr(8'h11);
      sfc_core_model_inst.issue(1'b0, 16'h0000, 8'h00, 8'h00);
      cyc(2);
      chk(rww_block, 1'b1, "reenable refused");
      wait_idle();
      wr(8'h11);
      sfc_core_model_inst.issue(1'b0, 16'h0000, 8'h00, 8'h00);
      cyc(2);
      chk(rww_block, 1'b0, "reenable");
      // Lock write, then both loads in one window
      wr(8'h09);
      sfc_core_model_inst.issue(1'b0, 16'hffff, 8'ha5, 8'h5a);
      cyc(2);
      chk(lock_bits, 8'ha5, "lock write");
      rdc(8'h00, "lock done");
      wr(8'h09);
      sfc_core_model_inst.issue(1'b1, 16'h0001, 8'h00, 8'h00);
      #1;
      chk(load_valid, 1'b1, "load valid");
      chk(load_data, fuse_bits, "fuse load");
      sfc_core_model_inst.issue(1'b1, 16'h0000, 8'h00, 8'h00);
      #1;
      chk(load_data, 8'ha5, "lock load");
      stop_test();
   end
endmodule
`default_nettype wire

/* File: dv/sfc_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Processor core side: store and load strobes with pointer and data registers
module sfc_core_model (
   // Clock
   input wire logic pclk,
   // Instruction side
   output logic store_req,
   output logic load_req,
   output logic [15:0] flash_addr_pointer,
   output logic [7:0] data_low_reg,
   output logic [7:0] data_high_reg
);
   // Quiet core at time zero
   initial begin
      store_req = 1'b0;
      load_req = 1'b0;
      flash_addr_pointer = 16'h0000;
      data_low_reg = 8'h00;
      data_high_reg = 8'h00;
   end
   // One instruction per call, entered just after a rising edge
   // Operands are inverted afterwards so a late sample cannot pass by luck
   task automatic issue(input logic ld, input logic [15:0] ptr, input logic [7:0] lo, input logic [7:0] hi);
      store_req <= ~ld;
      load_req <= ld;
      flash_addr_pointer <= ptr;
      data_low_reg <= lo;
      data_high_reg <= hi;
      @(posedge pclk);
      store_req <= 1'b0;
      load_req <= 1'b0;
      flash_addr_pointer <= ~ptr;
      data_low_reg <= ~lo;
      data_high_reg <= ~hi;
   endtask
endmodule
`default_nettype wire
